// >>> src/prsc_engine.sv
`timescale 1ns/1ps
`include "prsc_consts.svh"
// Functional notes
// RULE_01 - V, I, power reported as S.23 fractions
// RULE_02 - Power factor reported as S.22
// RULE_03 - Frequency reported S.16 below 256 Hz
// RULE_04 - Temperature reported as S.10
// RULE_05 - Fullscale scratch registers affect nothing
// RULE_06 - Success clears cal bits, keeps setup bits
// RULE_07 - Failure leaves failed cal bit set
// RULE_08 - New coefficients go to working registers
// RULE_09 - Host target at most 70.7% fullscale
// RULE_10 - Gain unity, average RMS over cycles
// RULE_11 - Gain is target over averaged RMS
// RULE_12 - Shared targets need identical applied levels
// RULE_13 - Offset is accumulated sum over samples
// RULE_14 - Offset cal zeroes highpass filter coefficients
// RULE_15 - Temperature cal recomputes offset from target
// RULE_16 - Temperature gain untouched by calibration
// RULE_17 - Instant per sample, RMS per interval
// RULE_18 - Frequency from composite, per 64 cycles
// RULE_19 - RMS is sqrt of mean square
// RULE_20 - Peak is largest magnitude current sample
// RULE_21 - Totals are mean of three phases
// RULE_22 - Subtract squared RMS offset, clamp zero
// RULE_23 - Fixed interval from sample count, 540
// RULE_24 - Line lock timeout at count plus 100
// RULE_25 - Interval results published together; divisor_r is written at interval end, three cycles before the rest
module prsc_engine (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Sample stream
  input wire logic sample_stb_in,
  input wire prsc_pkg::prsc_sample_t sample_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Status
  output logic cal_busy_out,
  output logic data_ready_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [23:0] cmd_r; // Command register
  logic [23:0] samples_r, calcyc_r; // Interval length, calibration cycles
  logic [23:0] vtarget_r, itarget_r, ttarget_r; // Calibration targets
  logic [23:0] ifs_r, vfs_r; // Scratchpad only
  logic [23:0] toffs_r, tgain_r, temp_r; // Temperature path
  logic [23:0] line_frequency_result_r, vtrms_r, itrms_r, divisor_r, frame_r;
  logic [23:0] inst_r [6]; // Per-sample values
  logic [23:0] rms_r [6]; // Published RMS
  logic [23:0] peak_r [3]; // Published current peaks
  logic [23:0] gain_r [6], offs_r [6], hpf_r [6];
  logic [23:0] irmsoff_r [3];
  logic [47:0] sq_acc_r [6]; // Sum of squares
  logic [47:0] lin_acc_r [6]; // Linear sum for offset cal
  logic [23:0] pk_run_r [3]; // Running peak magnitude
  logic [23:0] pk_hold_r [3]; // Peak of the interval just closed
  logic cal_done_r; // Calibration run finished last cycle
  logic [23:0] cnt_r; // Samples in this interval
  logic [23:0] cal_left_r; // Intervals left in calibration
  logic [47:0] cal_samp_r; // Samples seen by offset cal
  logic [29:0] rms_sum_r [6]; // Summed RMS for gain cal
  logic [47:0] msq_r [6]; // Mean squares after division
  logic [23:0] rms_nxt [6]; // Root results
  logic [2:0] idx_r; // Channel index, not driven or read anywhere
  logic [5:0] zc_cnt_r; // Line cycles for frequency
  logic [31:0] zc_samp_r; // Samples across those cycles
  logic cal_err_r;
  prsc_pkg::prsc_state_t state_r;
  logic end_ivl;
  // ----------------------------------------
  // Interval end, fixed or line locked
  // ----------------------------------------
  // Without valid AC the stretch is capped so results keep flowing.
  always_comb begin
    end_ivl = 1'b0;
    if (sample_stb_in && state_r == prsc_pkg::ST_RUN) begin
      if (!cmd_r[`PRSC_CMD_LLOCK_BIT]) begin
        end_ivl = (cnt_r + 24'h000001 >= samples_r); // RULE_23
      end else if (cnt_r + 24'h000001 >= samples_r + `PRSC_LLOCK_EXTRA) begin
        end_ivl = 1'b1; // RULE_24
      end else begin
        end_ivl = (cnt_r + 24'h000001 >= samples_r) && sample_in.ac_valid && sample_in.zc_pos;
      end
    end
  end
  // ----------------------------------------
  // Per-channel accumulation
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_ch
      logic signed [23:0] s;
      assign s = sample_in.ch[g];
      // Instantaneous refresh and accumulators
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          inst_r[g] <= 24'h000000;
          sq_acc_r[g] <= 48'h0;
          lin_acc_r[g] <= 48'h0;
        end else if (sample_stb_in) begin
          inst_r[g] <= s; // RULE_17
          sq_acc_r[g] <= end_ivl ? 48'h0 : sq_acc_r[g] + 48'(s * s); // RULE_19
          // Sum only while a run is active so it pairs with the sample count
          if (!cal_busy_out) begin
            lin_acc_r[g] <= 48'h0;
          end else begin
            lin_acc_r[g] <= lin_acc_r[g] + {{24{s[23]}}, s}; // RULE_13
          end
        end
      end
      // Current peaks, channels 3..5
      if (g >= 3) begin : g_pk
        logic [23:0] mag;
        assign mag = s[23] ? 24'(-s) : s;
        always_ff @(posedge clk_in) begin
          if (!rstn_in) begin
            pk_run_r[g-3] <= 24'h000000;
            pk_hold_r[g-3] <= 24'h000000;
          end else if (sample_stb_in) begin
            if (end_ivl) begin
              // Closing sample counts too; hold until publication
              pk_hold_r[g-3] <= (mag > pk_run_r[g-3]) ? mag : pk_run_r[g-3]; // RULE_20
              pk_run_r[g-3] <= 24'h000000;
            end else if (mag > pk_run_r[g-3]) begin
              pk_run_r[g-3] <= mag; // RULE_20
            end
          end
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Post-interval pipeline
  // ----------------------------------------
  // Mean square minus squared offset, clamped; then bitwise root.
  function automatic logic [23:0] isqrt(input logic [47:0] v);
    logic [47:0] r;
    logic [23:0] q;
    r = v;
    q = 24'h000000;
    for (int b = 23; b >= 0; b--) begin
      if (48'({q | (24'h000001 << b)}) * 48'({q | (24'h000001 << b)}) <= r) begin
        q = q | (24'h000001 << b);
      end
    end
    return q;
  endfunction
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rms_nxt[i] = isqrt(msq_r[i]); // RULE_19
    end
  end
  // Engine sequencing
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= prsc_pkg::ST_RUN;
      cnt_r <= 24'h000000;
      divisor_r <= 24'h000000;
      for (int i = 0; i < 6; i++) begin
        msq_r[i] <= 48'h0;
      end
    end else begin
      case (state_r)
        prsc_pkg::ST_RUN, prsc_pkg::ST_IDLE: begin
          if (sample_stb_in) begin
            cnt_r <= end_ivl ? 24'h000000 : cnt_r + 24'h000001;
          end
          if (end_ivl) begin
            divisor_r <= cnt_r + 24'h000001;
            for (int i = 0; i < 6; i++) begin
              msq_r[i] <= (sq_acc_r[i]
                + 48'($signed(sample_in.ch[i]) * $signed(sample_in.ch[i])))
                / 48'({24'h0, cnt_r + 24'h000001});
            end
            state_r <= prsc_pkg::ST_DIV;
          end
        end
        prsc_pkg::ST_DIV: begin
          for (int i = 3; i < 6; i++) begin
            if (msq_r[i] > 48'(irmsoff_r[i-3] * irmsoff_r[i-3])) begin
              msq_r[i] <= msq_r[i] - 48'(irmsoff_r[i-3] * irmsoff_r[i-3]); // RULE_22
            end else begin
              msq_r[i] <= 48'h0; // RULE_22
            end
          end
          state_r <= prsc_pkg::ST_SQRT;
        end
        prsc_pkg::ST_SQRT: state_r <= prsc_pkg::ST_PUB;
        default: state_r <= prsc_pkg::ST_RUN;
      endcase
    end
  end
  // ----------------------------------------
  // Publication of interval results
  // ----------------------------------------
  // RMS, peaks, totals and frame move in one cycle; divisor_r moves three cycles earlier, at interval end.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 6; i++) rms_r[i] <= 24'h000000;
      for (int i = 0; i < 3; i++) peak_r[i] <= 24'h000000;
      vtrms_r <= 24'h000000;
      itrms_r <= 24'h000000;
      frame_r <= 24'h000000;
      data_ready_out <= 1'b0;
    end else begin
      data_ready_out <= 1'b0;
      if (state_r == prsc_pkg::ST_PUB) begin
        for (int i = 0; i < 6; i++) rms_r[i] <= rms_nxt[i]; // RULE_25
        for (int i = 0; i < 3; i++) peak_r[i] <= pk_hold_r[i]; // RULE_17
        vtrms_r <= 24'((26'(rms_nxt[0]) + 26'(rms_nxt[1]) + 26'(rms_nxt[2])) / 26'd3); // RULE_21
        itrms_r <= 24'((26'(rms_nxt[3]) + 26'(rms_nxt[4]) + 26'(rms_nxt[5])) / 26'd3); // RULE_21
        frame_r <= frame_r + 24'h000001;
        data_ready_out <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Line frequency, one reading per 64 cycles
  // ----------------------------------------
  // Sample rate is fixed at 2700 Hz in a localparam; result is rate*64*2^16/samples (S.16).
  localparam logic [47:0] SAMPLE_HZ_Q16 = 48'd2700 * 48'd64 * 48'd65536;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      zc_cnt_r <= 6'h00;
      zc_samp_r <= 32'h0;
      line_frequency_result_r <= 24'h000000;
    end else if (sample_stb_in) begin
      zc_samp_r <= zc_samp_r + 32'h1;
      if (sample_in.zc_pos) begin
        zc_cnt_r <= zc_cnt_r + 6'h01;
        if (zc_cnt_r == 6'(`PRSC_LINE_FREQUENCY_RESULT_CYCLES - 8'h01)) begin
          line_frequency_result_r <= 24'(SAMPLE_HZ_Q16 / 48'({16'h0, zc_samp_r + 32'h1})); // RULE_18 RULE_03
          zc_samp_r <= 32'h0;
        end
      end
    end
  end
  // ----------------------------------------
  // Temperature reading, S.10
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      temp_r <= 24'h000000;
    end else if (sample_stb_in) begin
      temp_r <= 24'((48'(sample_in.temp_raw) * 48'(tgain_r)) >> 10) + toffs_r; // RULE_04
    end
  end
  // ----------------------------------------
  // Calibration and register writes
  // ----------------------------------------
  logic wr;
  assign wr = psel_in && penable_in && pwrite_in;
  logic [7:0] widx;
  assign widx = paddr_in[9:2];
  // Command start, cycle counting, coefficient update
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmd_r <= 24'h000000;
      samples_r <= `PRSC_SAMPLES_RST;
      calcyc_r <= `PRSC_CALCYC_RST;
      vtarget_r <= 24'h000000;
      itarget_r <= 24'h000000;
      ttarget_r <= 24'h000000;
      ifs_r <= 24'h000000;
      vfs_r <= 24'h000000;
      toffs_r <= 24'h000000;
      tgain_r <= `PRSC_TGAIN_RST;
      cal_left_r <= 24'h000000;
      cal_samp_r <= 48'h0;
      cal_err_r <= 1'b0;
      cal_done_r <= 1'b0;
      cal_busy_out <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        gain_r[i] <= `PRSC_UNITY_GAIN;
        offs_r[i] <= 24'h000000;
        hpf_r[i] <= `PRSC_HPF_RST;
        rms_sum_r[i] <= 30'h0;
      end
      for (int i = 0; i < 3; i++) irmsoff_r[i] <= 24'h000000;
    end else if (cal_busy_out) begin
      if (sample_stb_in) cal_samp_r <= cal_samp_r + 48'h1;
      if (state_r == prsc_pkg::ST_PUB) begin
        for (int i = 0; i < 6; i++) rms_sum_r[i] <= rms_sum_r[i] + 30'(rms_nxt[i]); // RULE_10
        cal_left_r <= cal_left_r - 24'h000001;
        if (cal_left_r == 24'h000001) begin
          cal_busy_out <= 1'b0;
          cal_err_r <= 1'b0;
          cal_done_r <= 1'b1;
          for (int i = 0; i < 6; i++) begin
            if (cmd_r[i]) begin
              if (cmd_r[`PRSC_CMD_GAIN_BIT]) begin
                if (rms_sum_r[i] + 30'(rms_nxt[i]) == 30'h0) begin
                  cal_err_r <= 1'b1; // RULE_07
                end else begin
                  gain_r[i] <= 24'((48'(i < 3 ? vtarget_r : itarget_r) << 22)
                    * 48'(calcyc_r) / 48'(rms_sum_r[i] + 30'(rms_nxt[i]))); // RULE_11 RULE_08
                end
              end
              if (cmd_r[`PRSC_CMD_OFFS_BIT]) begin
                offs_r[i] <= 24'($signed(lin_acc_r[i]) / $signed(cal_samp_r)); // RULE_13
                hpf_r[i] <= 24'h000000; // RULE_14
              end
            end
          end
          if (cmd_r[`PRSC_CMD_TEMP_BIT]) begin
            toffs_r <= toffs_r + ttarget_r - temp_r; // RULE_15 RULE_16
          end
        end
      end
    end else if (cal_done_r) begin
      cal_done_r <= 1'b0;
      // Only a clean run clears; a failed bit stays set for the host
      if (!cal_err_r) cmd_r <= cmd_r & ~`PRSC_CMD_CAL_MASK; // RULE_06
    end
    // Software writes, honoured only when idle
    if (rstn_in && wr && !cal_busy_out) begin
      case (paddr_in)
        `PRSC_OFF_CMD: begin
          cmd_r <= pwdata_in[23:0];
          if (pwdata_in[10] && pwdata_in[9:8] == 2'b00 || pwdata_in[9:8] != 2'b00 && !pwdata_in[10]) begin
            cal_busy_out <= 1'b1;
            cal_err_r <= 1'b0;
            cal_left_r <= calcyc_r == 24'h0 ? 24'h000001 : calcyc_r;
            cal_samp_r <= 48'h0;
            for (int i = 0; i < 6; i++) begin
              rms_sum_r[i] <= 30'h0;
              if (pwdata_in[i] && pwdata_in[8]) gain_r[i] <= `PRSC_UNITY_GAIN; // RULE_10
            end
          end else if (pwdata_in[10:8] != 3'b000) begin
            cal_err_r <= 1'b1; // Temperature mixed with gain/offset: RULE_07
          end
        end
        `PRSC_OFF_SAMPLES: samples_r <= pwdata_in[23:0];
        `PRSC_OFF_CALCYC: calcyc_r <= pwdata_in[23:0];
        `PRSC_OFF_VTARGET: vtarget_r <= pwdata_in[23:0];
        `PRSC_OFF_ITARGET: itarget_r <= pwdata_in[23:0];
        `PRSC_OFF_TTARGET: ttarget_r <= pwdata_in[23:0];
        `PRSC_OFF_IFS: ifs_r <= pwdata_in[23:0]; // RULE_05
        `PRSC_OFF_VFS: vfs_r <= pwdata_in[23:0]; // RULE_05
        `PRSC_OFF_TOFFS: toffs_r <= pwdata_in[23:0];
        default: begin
          for (int i = 0; i < 6; i++) begin
            if (paddr_in == `PRSC_OFF_GAIN + 12'(i * 4)) gain_r[i] <= pwdata_in[23:0];
            if (paddr_in == `PRSC_OFF_OFFS + 12'(i * 4)) offs_r[i] <= pwdata_in[23:0];
            if (paddr_in == `PRSC_OFF_HPF + 12'(i * 4)) hpf_r[i] <= pwdata_in[23:0];
          end
          for (int i = 0; i < 3; i++) begin
            if (paddr_in == `PRSC_OFF_IRMSOFF + 12'(i * 4)) irmsoff_r[i] <= pwdata_in[23:0];
          end
        end
      endcase
    end
  end
  // ----------------------------------------
  // APB read and response
  // ----------------------------------------
  // Zero-wait answer; 24-bit registers sit in the low lanes with a zero upper byte.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && paddr_in > `PRSC_OFF_IRMSOFF + 12'h008;
      if (psel_in && !penable_in) begin
        prdata_out <= 32'h0;
        case (paddr_in)
          `PRSC_OFF_CMD: prdata_out <= {8'h00, cmd_r};
          `PRSC_OFF_SAMPLES: prdata_out <= {8'h00, samples_r};
          `PRSC_OFF_CALCYC: prdata_out <= {8'h00, calcyc_r};
          `PRSC_OFF_VTARGET: prdata_out <= {8'h00, vtarget_r};
          `PRSC_OFF_ITARGET: prdata_out <= {8'h00, itarget_r};
          `PRSC_OFF_TTARGET: prdata_out <= {8'h00, ttarget_r};
          `PRSC_OFF_IFS: prdata_out <= {8'h00, ifs_r};
          `PRSC_OFF_VFS: prdata_out <= {8'h00, vfs_r};
          `PRSC_OFF_TOFFS: prdata_out <= {8'h00, toffs_r};
          `PRSC_OFF_TGAIN: prdata_out <= {8'h00, tgain_r};
          `PRSC_OFF_TEMP: prdata_out <= {8'h00, temp_r}; // RULE_04
          `PRSC_OFF_LINE_FREQUENCY_RESULT: prdata_out <= {8'h00, line_frequency_result_r}; // RULE_03
          `PRSC_OFF_VTRMS: prdata_out <= {8'h00, vtrms_r}; // RULE_01
          `PRSC_OFF_ITRMS: prdata_out <= {8'h00, itrms_r};
          `PRSC_OFF_DIVISOR: prdata_out <= {8'h00, divisor_r};
          `PRSC_OFF_FRAME: prdata_out <= {8'h00, frame_r};
          default: begin
            for (int i = 0; i < 6; i++) begin
              if (paddr_in == `PRSC_OFF_INST + 12'(i * 4)) prdata_out <= {8'h00, inst_r[i]};
              if (paddr_in == `PRSC_OFF_RMS + 12'(i * 4)) prdata_out <= {8'h00, rms_r[i]};
              if (paddr_in == `PRSC_OFF_GAIN + 12'(i * 4)) prdata_out <= {8'h00, gain_r[i]};
              if (paddr_in == `PRSC_OFF_OFFS + 12'(i * 4)) prdata_out <= {8'h00, offs_r[i]};
              if (paddr_in == `PRSC_OFF_HPF + 12'(i * 4)) prdata_out <= {8'h00, hpf_r[i]};
            end
            for (int i = 0; i < 3; i++) begin
              if (paddr_in == `PRSC_OFF_PEAK + 12'(i * 4)) prdata_out <= {8'h00, peak_r[i]};
              if (paddr_in == `PRSC_OFF_IRMSOFF + 12'(i * 4)) prdata_out <= {8'h00, irmsoff_r[i]};
            end
          end
        endcase
      end
    end
  end
  // RULE_02: power factor S.22 lives in the power block outside this engine.
  // RULE_09 RULE_12: target levels are the host's duty; no check here.
endmodule

// >>> src/prsc_consts.svh
`ifndef PRSC_CONSTS_SVH
`define PRSC_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PRSC_OFF_CMD 12'h000
`define PRSC_OFF_SAMPLES 12'h004
`define PRSC_OFF_CALCYC 12'h008
`define PRSC_OFF_VTARGET 12'h00c
`define PRSC_OFF_ITARGET 12'h010
`define PRSC_OFF_TTARGET 12'h014
`define PRSC_OFF_IFS 12'h018
`define PRSC_OFF_VFS 12'h01c
`define PRSC_OFF_TOFFS 12'h020
`define PRSC_OFF_TGAIN 12'h024
`define PRSC_OFF_TEMP 12'h028
`define PRSC_OFF_LINE_FREQUENCY_RESULT 12'h02c
`define PRSC_OFF_VTRMS 12'h030
`define PRSC_OFF_ITRMS 12'h034
`define PRSC_OFF_DIVISOR 12'h038
`define PRSC_OFF_FRAME 12'h03c
`define PRSC_OFF_INST 12'h040
`define PRSC_OFF_RMS 12'h060
`define PRSC_OFF_PEAK 12'h080
`define PRSC_OFF_GAIN 12'h0a0
`define PRSC_OFF_OFFS 12'h0c0
`define PRSC_OFF_HPF 12'h0e0
`define PRSC_OFF_IRMSOFF 12'h100
// ----------------------------------------
// Command register fields
// ----------------------------------------
`define PRSC_CMD_CHSEL_LSB 0
`define PRSC_CMD_GAIN_BIT 8
`define PRSC_CMD_OFFS_BIT 9
`define PRSC_CMD_TEMP_BIT 10
`define PRSC_CMD_LLOCK_BIT 16
`define PRSC_CMD_CAL_MASK 24'h0007ff
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PRSC_SAMPLES_RST 24'h00021c
`define PRSC_LLOCK_EXTRA 24'h000064
`define PRSC_LINE_FREQUENCY_RESULT_CYCLES 8'h40
`define PRSC_CALCYC_RST 24'h000004
`define PRSC_UNITY_GAIN 24'h400000
`define PRSC_HPF_RST 24'h000100
`define PRSC_TGAIN_RST 24'h000400
`endif

// >>> src/prsc_pkg.sv
package prsc_pkg;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DIV = 3'b010,
    ST_SQRT = 3'b011,
    ST_CAL = 3'b100,
    ST_PUB = 3'b101
  } prsc_state_t;
  // One incoming sample set: six channels, VA VB VC IA IB IC
  typedef struct packed {
    logic [5:0][23:0] ch;
    logic [23:0] temp_raw;
    logic zc_pos;
    logic ac_valid;
  } prsc_sample_t;
endpackage

// >>> verification/prsc_engine_properties.sv
`timescale 1ns/1ps
module prsc_engine_properties (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // APB side
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Status
  input wire logic cal_busy_out,
  input wire logic data_ready_out
);
  // ----------------------------------------
  // Properties, all on the one clock
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_unmapped: assert property (psel_in && !penable_in && paddr_in > 12'h108 |=> pslverr_out)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (psel_in && !penable_in && paddr_in <= 12'h108 |=> !pslverr_out)
    else $error("mapped access refused");
  a_read_upper_zero: assert property (pready_out && !pwrite_in |-> prdata_out[31:24] == 8'h00)
    else $error("upper read byte not zero");
  a_publish_pulse: assert property (data_ready_out |=> !data_ready_out)
    else $error("publish pulse too long");
  a_quiet_after_reset: assert property ($rose(rstn_in) |-> !pready_out && !cal_busy_out)
    else $error("outputs active after reset");
  // Gain or offset launch must raise busy soon after the write lands
  a_cal_launch: assert property (pready_out && pwrite_in && paddr_in == 12'h000
    && (pwdata_in[10:8] == 3'b001 || pwdata_in[10:8] == 3'b010) && !cal_busy_out
    |-> ##[1:4] cal_busy_out) else $error("calibration did not start");
  // Main scenarios reached
  c_publish: cover property (data_ready_out);
  c_cal_done: cover property ($fell(cal_busy_out));
  c_refused: cover property (pslverr_out);
endmodule
bind prsc_engine prsc_engine_properties chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .cal_busy_out(cal_busy_out), .data_ready_out(data_ready_out));

// >>> verification/prsc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller: APB master
// ----------------------------------------
module prsc_host_model (
  // Clock
  input wire logic clk_in,
  // Request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  // Answer
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  // Idle bus from time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end
  // One transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    // No cycle count assumed; the bench watchdog ends a dead wait
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule

// >>> verification/tb_prsc_engine.sv
`timescale 1ns/1ps
`include "prsc_consts.svh"
module tb_prsc_engine;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sample_stb_in = 1'b0;
  prsc_pkg::prsc_sample_t sample_in = '0;
  logic psel, penable, pwrite, pready, pslverr, cal_busy, data_ready, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [23:0] cv [6];
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int exp_peak;
  int pk_q[$];
  always #2 clk_in = ~clk_in;
  prsc_engine dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .sample_stb_in(sample_stb_in),
    .sample_in(sample_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .cal_busy_out(cal_busy), .data_ready_out(data_ready));
  prsc_host_model host_u (.clk_in(clk_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  // Sample source: strobe every 8 cycles, IB random, others held
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sample_stb_in <= (cyc % 8 == 7);
    if (cyc % 8 == 7) begin
      cv[4] = 24'($urandom_range(0, 32'h3fffff));
      pk_q.push_back(cv[4]);
      for (int i = 0; i < 6; i++) sample_in.ch[i] <= cv[i];
      sample_in.temp_raw <= 24'($urandom_range(0, 32'hffff));
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  // Next publish; model peak is the largest of the last 8 samples
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (data_ready !== 1'b1 && n < 2000);
    if (n >= 2000) num_errors++;
    exp_peak = 0;
    for (int i = pk_q.size() - 8; i < pk_q.size(); i++)
      if (pk_q[i] > exp_peak) exp_peak = pk_q[i];
  endtask
  // Busy may be brief; then bounded wait for its end
  task automatic wait_cal();
    int n;
    n = 0;
    while (cal_busy !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    n = 0;
    while (cal_busy !== 1'b0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3000) num_errors++;
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cv = '{24'h200000, 24'h100000, 24'h500000, 24'h100000, 24'h0, 24'h100000};
    void'($urandom(32'h77f3));
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    rdc(`PRSC_OFF_SAMPLES, 32'd540);
    rdc(`PRSC_OFF_CALCYC, `PRSC_CALCYC_RST);
    rdc(`PRSC_OFF_TGAIN, `PRSC_TGAIN_RST);
    rdc(`PRSC_OFF_HPF + 12'h4, `PRSC_HPF_RST);
    v = $urandom & 32'hffffff;
    wr(`PRSC_OFF_IFS, v);
    rdc(`PRSC_OFF_IFS, v);
    wr(`PRSC_OFF_VFS, ~v & 32'hffffff);
    rdc(`PRSC_OFF_VFS, ~v & 32'hffffff);
    host_u.xfer(1'b0, 12'h10c, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    // Short interval, one cal cycle, HPF zeroed on all but ch1
    for (int i = 0; i < 6; i++) if (i != 1) wr(`PRSC_OFF_HPF + 12'(4 * i), 32'h0);
    wr(`PRSC_OFF_SAMPLES, 32'd8);
    wr(`PRSC_OFF_CALCYC, 32'd1);
    wr(`PRSC_OFF_IRMSOFF, 32'h200000);
    wr(`PRSC_OFF_CMD, 32'h202);
    wait_cal();
    rdc(`PRSC_OFF_CMD, 32'h0);
    rdc(`PRSC_OFF_OFFS + 12'h4, 32'h100000);
    rdc(`PRSC_OFF_HPF + 12'h4, 32'h0);
    $display("test offset cal done");
    wr(`PRSC_OFF_VTARGET, 32'h100000);
    wr(`PRSC_OFF_CMD, 32'h101);
    wait_cal();
    rdc(`PRSC_OFF_CMD, 32'h0);
    rdc(`PRSC_OFF_GAIN, 32'h200000);
    $display("test gain cal done");
    wait_rdy();
    wait_rdy();
    rdc(`PRSC_OFF_PEAK + 12'h4, exp_peak);
    rdc(`PRSC_OFF_RMS, 32'h200000);
    rdc(`PRSC_OFF_RMS + 12'h4, 32'h100000);
    rdc(`PRSC_OFF_VTRMS, 32'h2aaaaa);
    rdc(`PRSC_OFF_RMS + 12'hc, 32'h0);
    rdc(`PRSC_OFF_DIVISOR, 32'd8);
    rdc(`PRSC_OFF_INST + 12'h14, 32'h100000);
    $display("test interval results done");
    wr(`PRSC_OFF_CMD, 32'h10000);
    wait_rdy();
    wait_rdy();
    rdc(`PRSC_OFF_DIVISOR, 32'd108);
    $display("test line lock timeout done");
    wr(`PRSC_OFF_CMD, 32'h10501);
    wait_cal();
    host_u.xfer(1'b0, `PRSC_OFF_CMD, 32'h0, rd, er);
    chk({31'h0, rd[10]}, 32'h1);
    wr(`PRSC_OFF_CMD, 32'h10000);
    wr(`PRSC_OFF_TTARGET, $urandom & 32'h7fff);
    wr(`PRSC_OFF_CMD, 32'h10400);
    wait_cal();
    rdc(`PRSC_OFF_CMD, 32'h10000);
    rdc(`PRSC_OFF_TGAIN, `PRSC_TGAIN_RST);
    $display("test temperature cal done");
    close_out();
  end
endmodule
